// *** pkg/ddr_sio_sram_defs.vh ***
// Constants for the double-data-rate separate-IO burst SRAM port
`ifndef DDR_SIO_SRAM_DEFS_VH
`define DDR_SIO_SRAM_DEFS_VH
`define CLK_PERIOD_NS 100
`define WORD_W 18
`define LANE_W 9
`define BURST_W 36
`define ADDR_W 20
`define FIFO_DEPTH 32
`define FIFO_AW 5
`define DLL_LOCK_CYC 1024
`define ZQ_UPDATE_CYC 1024
`define DLL_STOP_NS 30
`define DLL_STOP_CYC ((`DLL_STOP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define K_NOMINAL_CYC 8
`define STRAP_WAIT 2'h3
`define OUT_IDLE 1'b0
`define OUT_SECOND 1'b1
`endif

// *** rtl/ddr_sio_sram_burst2_port.v ***
// Burst SRAM port logic with synchronisers, read FIFO and posted write
`timescale 1ns/1ps
`include "ddr_sio_sram_defs.vh"
// Function
// - Latency pin high gives 1.5 cycle read latency, low gives one cycle
// - Accesses start only on rising edges of the positive input clock
// - Write data captured on rising edges of both input clocks
// - Read data launched on output clock rises, or input clocks if strapped
// - Select and load strobe registered on positive input clock rise, masks on both input clock rises
// - Select high with load low starts a read, address stored
// - Read returns two 18-bit words, lower address first, next edge second
// - With latency pin high, first word at negative output rise t+1, second at positive t+2
// - A new read accepted every cycle, streaming a word per edge
// - Deselected reads finish bursts, outputs off after next positive output rise
// - Select low with load low starts a write, address stored
// - Write words on next positive then negative input rise, 36 bits committed
// - A new write accepted every positive input clock rise
// - Deselected writes complete pending work, then inputs are ignored
// - Active-low lane masks sampled per word; deasserted lane keeps stored byte
// - Both output clocks high at power-on select single-clock mode, fixed
// - Write held in a posted register, committed on the next write
// - Output impedance re-tuned once every 1024 cycles
// - Two free-running echo strobes follow the output or input clock pair
// - DLL locks 1024 cycles after a stable input clock
// - Input clock stopped 30 ns or more resets the DLL, which relocks
// - Latency pin low disables the DLL, one cycle read latency
// - Powers up deselected with read outputs tri-stated

// =====================================================================
// Two flip-flop synchroniser
module sync_2ff #(
  parameter WIDTH = 1
) (
  clk,
  reset_n,
  din,
  dout
);
  input wire clk;
  input wire reset_n;
  input wire [WIDTH-1:0] din;
  output reg [WIDTH-1:0] dout;
  reg [WIDTH-1:0] meta_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // sync_2ff

// =====================================================================
// Stream FIFO
module stream_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  clk,
  reset_n,
  inValid,
  inReady,
  inData,
  outValid,
  outReady,
  outData
);
  input wire clk;
  input wire reset_n;
  input wire inValid;
  output wire inReady;
  input wire [WIDTH-1:0] inData;
  output wire outValid;
  input wire outReady;
  output wire [WIDTH-1:0] outData;
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;
  assign inReady = (count_q != DEPTH);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData = store[rdPtr_q];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  always @(posedge clk) begin
    if (push) begin
      store[wrPtr_q] <= inData;
    end
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // stream_fifo

// =====================================================================
// Top level port logic
module ddr_sio_sram_burst2_port (
  clk,
  reset_n,
  inClkPos,
  inClkNeg,
  outClkPos,
  outClkNeg,
  address,
  loadStrobeN,
  readWriteSel,
  byteLaneMaskN,
  writeData,
  latencyModePin,
  readData,
  readDataOe,
  echoStrobePos,
  echoStrobeNeg,
  dllLocked,
  impedanceUpdate
);
  input wire clk;
  input wire reset_n;
  input wire inClkPos;
  input wire inClkNeg;
  input wire outClkPos;
  input wire outClkNeg;
  input wire [`ADDR_W-1:0] address;
  input wire loadStrobeN;
  input wire readWriteSel;
  input wire [1:0] byteLaneMaskN;
  input wire [`WORD_W-1:0] writeData;
  input wire latencyModePin;
  output reg [`WORD_W-1:0] readData;
  output reg readDataOe;
  output reg echoStrobePos;
  output reg echoStrobeNeg;
  output reg dllLocked;
  output reg impedanceUpdate;

  // ===================================================================
  // Input synchronisers and edge detection
  wire [3:0] clkSync;
  wire [`ADDR_W+`WORD_W+4:0] pinSync;
  reg [3:0] clkPrev_q;
  sync_2ff #(.WIDTH(4)) clkSyncInst (
    .clk(clk),
    .reset_n(reset_n),
    .din({outClkNeg, outClkPos, inClkNeg, inClkPos}),
    .dout(clkSync)
  );
  sync_2ff #(.WIDTH(`ADDR_W+`WORD_W+5)) pinSyncInst (
    .clk(clk),
    .reset_n(reset_n),
    .din({latencyModePin, byteLaneMaskN, readWriteSel, loadStrobeN, writeData, address}),
    .dout(pinSync)
  );
  wire [`ADDR_W-1:0] addrS = pinSync[`ADDR_W-1:0];
  wire [`WORD_W-1:0] dataS = pinSync[`ADDR_W+`WORD_W-1:`ADDR_W];
  wire loadNS = pinSync[`ADDR_W+`WORD_W];
  wire rwS = pinSync[`ADDR_W+`WORD_W+1];
  wire [1:0] maskNS = pinSync[`ADDR_W+`WORD_W+3:`ADDR_W+`WORD_W+2];
  wire dllOn = pinSync[`ADDR_W+`WORD_W+4];
  wire [3:0] clkRise = clkSync & ~clkPrev_q;
  wire kRise = clkRise[0];
  wire knRise = clkRise[1];

  // ===================================================================
  // Single-clock strap
  reg [1:0] strapCnt_q;
  reg strapDone_q;
  reg singleClk_q;
  wire outPosRise = singleClk_q ? clkRise[0] : clkRise[2];
  wire outNegRise = singleClk_q ? clkRise[1] : clkRise[3];
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clkPrev_q <= 4'h0;
      strapCnt_q <= 2'h0;
      strapDone_q <= 1'b0;
      singleClk_q <= 1'b0;
    end else begin
      clkPrev_q <= clkSync;
      if (!strapDone_q) begin
        if (strapCnt_q == `STRAP_WAIT) begin
          strapDone_q <= 1'b1;
          singleClk_q <= clkSync[2] & clkSync[3];
        end else begin
          strapCnt_q <= strapCnt_q + 1'b1;
        end
      end
    end
  end

  // ===================================================================
  // Command decode
  wire fifoInReady;
  wire loadOk = kRise & ~loadNS;
  wire readReq = loadOk & rwS & fifoInReady;
  wire writeReq = loadOk & ~rwS;

  // ===================================================================
  // Write capture and posted write
  reg [`BURST_W-1:0] mem [0:(1<<`ADDR_W)-1];
  reg wrArmed_q;
  reg [`ADDR_W-1:0] wrAddr_q;
  reg capBusy_q;
  reg [`ADDR_W-1:0] capAddr_q;
  reg [`WORD_W-1:0] capWord0_q;
  reg [1:0] capEn0_q;
  reg postValid_q;
  reg [`ADDR_W-1:0] postAddr_q;
  reg [`BURST_W-1:0] postData_q;
  reg [3:0] postEn_q;
  wire captureDone = knRise & capBusy_q;
  wire commitNow = captureDone & postValid_q;

  function [`BURST_W-1:0] laneBits;
    input [3:0] en;
    begin
      laneBits = {{`LANE_W{en[3]}}, {`LANE_W{en[2]}}, {`LANE_W{en[1]}}, {`LANE_W{en[0]}}};
    end
  endfunction

  wire [`BURST_W-1:0] postMask = laneBits(postEn_q);
  always @(posedge clk) begin
    if (commitNow) begin
      mem[postAddr_q] <= (mem[postAddr_q] & ~postMask) | (postData_q & postMask);
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrArmed_q <= 1'b0;
      wrAddr_q <= {`ADDR_W{1'b0}};
      capBusy_q <= 1'b0;
      capAddr_q <= {`ADDR_W{1'b0}};
      capWord0_q <= {`WORD_W{1'b0}};
      capEn0_q <= 2'h0;
      postValid_q <= 1'b0;
      postAddr_q <= {`ADDR_W{1'b0}};
      postData_q <= {`BURST_W{1'b0}};
      postEn_q <= 4'h0;
    end else begin
      if (kRise) begin
        wrArmed_q <= writeReq;
        if (writeReq) begin
          wrAddr_q <= addrS;
        end
        capBusy_q <= wrArmed_q;
        if (wrArmed_q) begin
          capAddr_q <= wrAddr_q;
          capWord0_q <= dataS;
          capEn0_q <= ~maskNS;
        end
      end
      if (captureDone) begin
        capBusy_q <= 1'b0;
        postValid_q <= 1'b1;
        postAddr_q <= capAddr_q;
        postData_q <= {dataS, capWord0_q};
        postEn_q <= {~maskNS, capEn0_q};
      end
    end
  end

  // ===================================================================
  // Read lookup and read FIFO
  wire fifoOutValid;
  wire [`ADDR_W-1:0] fifoOutAddr;
  wire [`BURST_W-1:0] arrayWord = mem[fifoOutAddr];
  wire postHit = postValid_q & (postAddr_q == fifoOutAddr);
  wire [`BURST_W-1:0] readWord = postHit ? ((arrayWord & ~postMask) | (postData_q & postMask)) : arrayWord;
  reg readStage_q;
  reg [1:0] dueCnt_q;
  reg outPhase_q;
  reg [`WORD_W-1:0] secondWord_q;
  wire dueInc = kRise & readStage_q;
  wire firstEdge = dllOn ? outNegRise : outPosRise;
  wire secondEdge = dllOn ? outPosRise : outNegRise;
  wire dueAvail = (dueCnt_q != 2'h0) | dueInc;
  wire popNow = firstEdge & dueAvail & fifoOutValid;
  stream_fifo #(.WIDTH(`ADDR_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) readFifo (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(readReq),
    .inReady(fifoInReady),
    .inData(addrS),
    .outValid(fifoOutValid),
    .outReady(popNow),
    .outData(fifoOutAddr)
  );

  // ===================================================================
  // Read output sequencing
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readStage_q <= 1'b0;
      dueCnt_q <= 2'h0;
      outPhase_q <= `OUT_IDLE;
      secondWord_q <= {`WORD_W{1'b0}};
      readData <= {`WORD_W{1'b0}};
      readDataOe <= 1'b0;
    end else begin
      if (kRise) begin
        readStage_q <= readReq;
      end
      if (dueInc & ~popNow) begin
        dueCnt_q <= dueCnt_q + 1'b1;
      end else if (popNow & ~dueInc) begin
        dueCnt_q <= dueCnt_q - 1'b1;
      end
      case (outPhase_q)
        `OUT_IDLE: begin
          if (popNow) begin
            readData <= readWord[`WORD_W-1:0];
            secondWord_q <= readWord[`BURST_W-1:`WORD_W];
            readDataOe <= 1'b1;
            outPhase_q <= `OUT_SECOND;
          end else if (outPosRise) begin
            readDataOe <= 1'b0;
          end
        end
        `OUT_SECOND: begin
          if (secondEdge) begin
            readData <= secondWord_q;
            outPhase_q <= `OUT_IDLE;
          end
        end
        default: begin
          outPhase_q <= `OUT_IDLE;
        end
      endcase
    end
  end

  // ===================================================================
  // Echo strobes, DLL lock and impedance cadence
  reg [10:0] lockCnt_q;
  reg [7:0] gapCnt_q;
  reg [9:0] zqCnt_q;
  wire clkStopped = (gapCnt_q >= (`K_NOMINAL_CYC + `DLL_STOP_CYC));
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      echoStrobePos <= 1'b0;
      echoStrobeNeg <= 1'b0;
      lockCnt_q <= 11'h000;
      gapCnt_q <= 8'h00;
      zqCnt_q <= 10'h000;
      dllLocked <= 1'b0;
      impedanceUpdate <= 1'b0;
    end else begin
      echoStrobePos <= singleClk_q ? clkSync[0] : clkSync[2];
      echoStrobeNeg <= singleClk_q ? clkSync[1] : clkSync[3];
      if (kRise) begin
        gapCnt_q <= 8'h00;
      end else if (!clkStopped) begin
        gapCnt_q <= gapCnt_q + 1'b1;
      end
      if (!dllOn || clkStopped) begin
        lockCnt_q <= 11'h000;
        dllLocked <= 1'b0;
      end else if (kRise && !dllLocked) begin
        if (lockCnt_q == (`DLL_LOCK_CYC - 1)) begin
          dllLocked <= 1'b1;
        end
        lockCnt_q <= lockCnt_q + 1'b1;
      end
      impedanceUpdate <= 1'b0;
      if (kRise) begin
        if (zqCnt_q == (`ZQ_UPDATE_CYC - 1)) begin
          zqCnt_q <= 10'h000;
          impedanceUpdate <= 1'b1;
        end else begin
          zqCnt_q <= zqCnt_q + 1'b1;
        end
      end
    end
  end
endmodule // ddr_sio_sram_burst2_port

// *** tb/ddr_sio_sram_burst2_port_properties.sv ***
// Assertion checker for the burst SRAM port
`timescale 1ns/1ps
module ddr_sio_sram_burst2_port_checker (
  input wire clk,
  input wire reset_n,
  input wire inClkPos,
  input wire outClkPos,
  input wire loadStrobeN,
  input wire readWriteSel,
  input wire latencyModePin,
  input wire readDataOe,
  input wire echoStrobePos,
  input wire dllLocked,
  input wire impedanceUpdate
);
  // ====================
  // Helper counters
  logic [7:0] lastRead;
  logic [7:0] firstRead;
  logic [11:0] kRises;
  logic [11:0] kImp;
  logic impSeen;
  wire rdLoad = !loadStrobeN && readWriteSel;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lastRead <= 8'hff;
      firstRead <= 8'hff;
      kRises <= 12'h000;
      kImp <= 12'h000;
      impSeen <= 1'b0;
    end else begin
      lastRead <= ($rose(inClkPos) && rdLoad) ? 8'h00 : lastRead + {7'h00, lastRead != 8'hff};
      firstRead <= ($rose(inClkPos) && rdLoad && firstRead > 8'h07) ? 8'h00 : firstRead + {7'h00, firstRead != 8'hff};
      kRises <= kRises + {11'h000, $rose(inClkPos) && kRises != 12'hfff};
      kImp <= impedanceUpdate ? 12'h000 : kImp + {11'h000, $rose(inClkPos)};
      impSeen <= impSeen | impedanceUpdate;
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_oe_reset; $rose(reset_n) |-> !readDataOe [*8]; endproperty
  property p_oe_rise;
    $rose(readDataOe) |-> (latencyModePin ? (firstRead inside {[12:18]}) : (firstRead inside {[8:14]}));
  endproperty
  property p_oe_fall;
    $fell(readDataOe) |-> (latencyModePin ? (lastRead inside {[24:30]}) : (lastRead inside {[16:22]}));
  endproperty
  property p_oe_idle; lastRead > 8'h28 |-> !readDataOe; endproperty
  property p_imp_pulse; impedanceUpdate |=> !impedanceUpdate [*7]; endproperty
  property p_imp_period; impedanceUpdate && impSeen |-> kImp == 12'h400; endproperty
  property p_echo; $rose(outClkPos) |-> ##[2:5] echoStrobePos; endproperty
  property p_lock; $rose(dllLocked) |-> kRises inside {[1022:1027]}; endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("read enable after reset");
  a_oe_rise: assert property (p_oe_rise) else $error("first word at wrong time");
  a_oe_fall: assert property (p_oe_fall) else $error("read enable dropped at wrong time");
  a_oe_idle: assert property (p_oe_idle) else $error("read enable without read");
  a_imp_pulse: assert property (p_imp_pulse) else $error("update pulse too long");
  a_imp_period: assert property (p_imp_period) else $error("update period wrong");
  a_echo: assert property (p_echo) else $error("echo strobe not following");
  a_lock: assert property (p_lock) else $error("lock time wrong");
  c_read: cover property ($rose(readDataOe));
  c_imp: cover property (impedanceUpdate && impSeen);
  c_lock: cover property ($rose(dllLocked));
endmodule // ddr_sio_sram_burst2_port_checker

bind ddr_sio_sram_burst2_port ddr_sio_sram_burst2_port_checker i_chk (
  .clk, .reset_n, .inClkPos, .outClkPos, .loadStrobeN, .readWriteSel,
  .latencyModePin, .readDataOe, .echoStrobePos, .dllLocked, .impedanceUpdate);

// *** tb/mem_ctrl_model.sv ***
// Memory controller model driving the burst SRAM pins
`timescale 1ns/1ps
`include "ddr_sio_sram_defs.vh"
module mem_ctrl_model (
  input wire clk,
  output logic inClkPos,
  output logic inClkNeg,
  output logic [`ADDR_W-1:0] address,
  output logic loadStrobeN,
  output logic readWriteSel,
  output logic [1:0] byteLaneMaskN,
  output logic [`WORD_W-1:0] writeData
);
  logic [2:0] ph = 3'h0;
  logic haveCmd = 1'b0;
  logic cRd, wPend, w1Go;
  logic [`ADDR_W-1:0] cAddr;
  logic [`WORD_W-1:0] cW0, cW1, w0, w1, d1;
  logic [1:0] cM0, cM1, m0, m1, dm1;
  initial begin
    {loadStrobeN, readWriteSel, address, byteLaneMaskN, writeData} = '1;
    {wPend, w1Go} = 2'h0;
  end
  // ====================
  // Free running pair, never both high
  assign inClkPos = !ph[2];
  assign inClkNeg = ph[2];
  always @(negedge clk) begin
    ph <= ph + 3'h1;
    if (ph == 3'h5) begin
      loadStrobeN <= !haveCmd;
      readWriteSel <= cRd;
      address <= haveCmd ? cAddr : ~address;
      writeData <= wPend ? w0 : ~writeData;
      byteLaneMaskN <= wPend ? m0 : ~byteLaneMaskN;
      w1Go <= wPend;
      d1 <= w1;
      dm1 <= m1;
      wPend <= haveCmd && !cRd;
      {w0, w1, m0, m1} <= {cW0, cW1, cM0, cM1};
      haveCmd = 1'b0;
    end
    if (ph == 3'h1 && w1Go) begin
      writeData <= d1;
      byteLaneMaskN <= dm1;
    end
  end
  task automatic op(input logic rd, input logic [`ADDR_W-1:0] a, input logic [`WORD_W-1:0] x0,
      input logic [`WORD_W-1:0] x1, input logic [1:0] k0, input logic [1:0] k1);
    wait (!haveCmd);
    {cRd, cAddr, cW0, cW1, cM0, cM1} = {rd, a, x0, x1, k0, k1};
    haveCmd = 1'b1;
  endtask
endmodule // mem_ctrl_model

// *** tb/tb.sv ***
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ps
`include "ddr_sio_sram_defs.vh"
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic latencyModePin = 1'b1;
  logic strapHigh = 1'b0;
  wire inClkPos, inClkNeg, loadStrobeN, readWriteSel, readDataOe, dllLocked, impedanceUpdate;
  wire echoStrobePos, echoStrobeNeg;
  wire [`ADDR_W-1:0] address;
  wire [1:0] byteLaneMaskN;
  wire [`WORD_W-1:0] writeData, readData;
  int nErrors = 0;
  int totalChecks = 0;
  logic [`WORD_W-1:0] got [4];
  initial begin
    forever #50 clk = ~clk;
  end
  ddr_sio_sram_burst2_port i_dut (.clk(clk), .reset_n(reset_n), .inClkPos(inClkPos),
    .inClkNeg(inClkNeg), .outClkPos(inClkPos | strapHigh), .outClkNeg(inClkNeg | strapHigh), .address(address),
    .loadStrobeN(loadStrobeN), .readWriteSel(readWriteSel), .byteLaneMaskN(byteLaneMaskN),
    .writeData(writeData), .latencyModePin(latencyModePin), .readData(readData),
    .readDataOe(readDataOe), .echoStrobePos(echoStrobePos), .echoStrobeNeg(echoStrobeNeg), .dllLocked(dllLocked),
    .impedanceUpdate(impedanceUpdate));
  mem_ctrl_model i_ctrl (.clk(clk), .inClkPos(inClkPos), .inClkNeg(inClkNeg), .address(address),
    .loadStrobeN(loadStrobeN), .readWriteSel(readWriteSel), .byteLaneMaskN(byteLaneMaskN),
    .writeData(writeData));
  // ====================
  // Shared tasks
  task automatic chk(input logic [`WORD_W-1:0] g, input logic [`WORD_W-1:0] e);
    totalChecks++;
    if (g !== e) begin
      nErrors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`WORD_W-1:0] x0,
      input logic [`WORD_W-1:0] x1, input logic [1:0] k0, input logic [1:0] k1);
    i_ctrl.op(1'b0, a, x0, x1, k0, k1);
  endtask
  task automatic rd(input logic [`ADDR_W-1:0] a);
    i_ctrl.op(1'b1, a, 18'h0_0000, 18'h0_0000, 2'h0, 2'h0);
  endtask
  task automatic grab(input int n);
    int i;
    for (i = 0; i < 60 && readDataOe !== 1'b1; i++) begin
      @(negedge clk);
    end
    chk({17'h0_0000, readDataOe}, 18'h0_0001);
    for (i = 0; i < n; i++) begin
      got[i] = readData;
      repeat (4) @(negedge clk);
    end
    repeat (12) @(negedge clk);
    chk({17'h0_0000, readDataOe}, 18'h0_0000);
  endtask
  // ====================
  // Scenarios
  task automatic tLock;
    int i;
    chk({17'h0_0000, readDataOe}, 18'h0_0000);
    for (i = 0; i < 9000 && dllLocked !== 1'b1; i++) begin
      @(negedge clk);
    end
    chk({17'h0_0000, dllLocked}, 18'h0_0001);
  endtask
  task automatic tPosted;
    wr(20'h0_0010, 18'h1_2345, 18'h2_6789, 2'h0, 2'h0);
    rd(20'h0_0010);
    grab(2);
    chk(got[0], 18'h1_2345);
    chk(got[1], 18'h2_6789);
    wr(20'h0_0020, 18'h0_1111, 18'h0_2222, 2'h0, 2'h0);
    rd(20'h0_0010);
    grab(2);
    chk(got[0], 18'h1_2345);
    chk(got[1], 18'h2_6789);
  endtask
  task automatic tMask;
    wr(20'h0_0030, 18'h3_ffff, 18'h3_ffff, 2'h0, 2'h0);
    wr(20'h0_0030, 18'h0_0000, 18'h0_0000, 2'h2, 2'h1);
    rd(20'h0_0030);
    grab(2);
    chk(got[0], 18'h3_fe00);
    chk(got[1], 18'h0_01ff);
  endtask
  task automatic tStream;
    wr(20'h0_0040, 18'h0_0abc, 18'h0_0def, 2'h0, 2'h0);
    rd(20'h0_0010);
    rd(20'h0_0030);
    grab(4);
    chk(got[0], 18'h1_2345);
    chk(got[1], 18'h2_6789);
    chk(got[2], 18'h3_fe00);
    chk(got[3], 18'h0_01ff);
  endtask
  task automatic tImp;
    int i;
    int n;
    for (i = 0; i < 9000 && impedanceUpdate !== 1'b1; i++) begin
      @(negedge clk);
    end
    n = 0;
    @(negedge clk);
    for (i = 0; i < 9000 && impedanceUpdate !== 1'b1; i++) begin
      @(negedge clk);
      n++;
    end
    chk(18'(n + 1), 18'h0_2000);
  endtask
  task automatic tDllOff;
    latencyModePin = 1'b0;
    repeat (8) @(negedge clk);
    rd(20'h0_0040);
    grab(2);
    chk(got[0], 18'h0_0abc);
    chk(got[1], 18'h0_0def);
  endtask
  task automatic tSingle;
    logic p;
    logic q;
    reset_n = 1'b0;
    strapHigh = 1'b1;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    chk({17'h0_0000, readDataOe}, 18'h0_0000);
    wr(20'h0_0050, 18'h0_5555, 18'h2_aaaa, 2'h0, 2'h0);
    rd(20'h0_0050);
    grab(2);
    chk(got[0], 18'h0_5555);
    chk(got[1], 18'h2_aaaa);
    p = inClkPos;
    q = inClkNeg;
    repeat (2) @(negedge clk);
    chk({16'h0000, echoStrobeNeg, echoStrobePos}, {16'h0000, q, p});
  endtask
  task automatic printVerdict;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #(40000 * `CLK_PERIOD_NS);
    nErrors++;
    printVerdict;
  end
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    tLock;
    tPosted;
    tMask;
    tStream;
    tImp;
    tDllOff;
    tSingle;
    printVerdict;
  end
endmodule // tb
